// ==== logic/tpc_timer_core.sv ====
`timescale 1ns/10ps
`include "tpc_consts.svh"

module tpc_timer_core
  import tpc_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [`TPC_ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [`TPC_DAT_W-1:0]     wb_dat_i,
  output logic      [`TPC_DAT_W-1:0]     wb_dat_o,
  output logic                           wb_ack_o,
  // Clock sources from outside this clock domain
  input  wire logic                      fixed_system_clock_i,
  input  wire logic                      external_timer_clock_i,
  // Channel pins
  input  wire logic [`TPC_NUM_CH-1:0]    channel_pin_i,
  output logic      [`TPC_NUM_CH-1:0]    channel_pin_o,
  output logic      [`TPC_NUM_CH-1:0]    channel_pin_oe_o,
  output logic      [`TPC_NUM_CH-1:0]    channel_pin_owned_o,
  output logic      [`TPC_NUM_CH-1:0]    channel_pullup_o,
  // Interrupt requests
  output logic                           overflow_irq_o,
  output logic      [`TPC_NUM_CH-1:0]    channel_irq_o
);

  // Bus handshake
  logic                    ack_reg;         // Acknowledge, one cycle
  logic [`TPC_DAT_W-1:0]   dat_reg;         // Registered read data
  logic [`TPC_DAT_W-1:0]   rdata_next;      // Read data being selected
  logic                    req;             // New access this cycle
  logic                    wr;              // New write this cycle
  logic                    rd;              // New read this cycle
  logic                    lo_en;           // Low byte lane enabled
  logic                    hi_en;           // High byte lane enabled
  logic                    sc_hit;          // Status/control addressed
  logic                    cnt_hit;         // Counter addressed
  logic                    mod_hit;         // Modulo addressed
  logic                    pue_hit;         // Pullup enables addressed

  // Timer state
  tpc_ctl_t                ctl_reg;         // Control fields
  logic                    tof_reg;         // Overflow flag
  logic                    tof_arm_reg;     // Flag read while set
  logic [`TPC_CNT_W-1:0]   cnt_reg;         // Counter
  logic [`TPC_CNT_W-1:0]   mod_reg;         // Modulo value
  logic [`TPC_NUM_CH-1:0]  pue_reg;         // Pullup enables
  tpc_dir_t                dir_reg;         // Counting direction
  logic [`TPC_PRE_W-1:0]   pre_reg;         // Prescaler count
  logic [`TPC_PRE_W-1:0]   pre_mask;        // Prescaler tap mask
  logic [`TPC_PRE_W:0]     pre_hot;         // One-hot divisor
  logic [`TPC_CNT_W-1:0]   top;             // Effective top count
  logic                    src_tick;        // Selected source edge
  logic                    tick;            // Prescaler output
  logic                    ovf_evt;         // Overflow this cycle
  logic                    cnt_wr;          // Any counter byte write
  logic                    fix_rise;        // Fixed clock rising edge
  logic                    ext_rise;        // External clock rising edge

  // Per-channel read contributions
  logic [`TPC_DAT_W-1:0]   ch_rd [`TPC_NUM_CH];

  // Bus decode; the ack gate makes each access act exactly once
  assign req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr      = req & wb_we_i;
  assign rd      = req & ~wb_we_i;
  assign lo_en   = wb_sel_i[0];
  assign hi_en   = wb_sel_i[1];
  assign sc_hit  = (wb_adr_i == `TPC_ADDR_SC);
  assign cnt_hit = (wb_adr_i == `TPC_ADDR_CNT);
  assign mod_hit = (wb_adr_i == `TPC_ADDR_MOD);
  assign pue_hit = (wb_adr_i == `TPC_ADDR_PUE);
  assign cnt_wr  = wr & cnt_hit & (lo_en | hi_en);

  // Acknowledge one cycle after the request, unmapped addresses too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Read data captured with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= '0;
    end else if (rd) begin
      dat_reg <= rdata_next;
    end
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    rdata_next = '0;
    if (sc_hit) begin
      rdata_next[`TPC_FLAG_BIT]  = tof_reg;
      rdata_next[`TPC_CTL_MSB:0] = ctl_reg;
    end else if (cnt_hit) begin
      rdata_next[`TPC_CNT_W-1:0] = cnt_reg;
    end else if (mod_hit) begin
      rdata_next[`TPC_CNT_W-1:0] = mod_reg;
    end else if (pue_hit) begin
      rdata_next[`TPC_NUM_CH-1:0] = pue_reg;
    end
    for (int k = 0; k < `TPC_NUM_CH; k++) begin
      rdata_next = rdata_next | ch_rd[k];
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;

  // Control fields; low byte lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= tpc_ctl_t'(`TPC_CTL_RST);
    end else if (wr && sc_hit && lo_en) begin
      ctl_reg <= tpc_ctl_t'(wb_dat_i[`TPC_CTL_MSB:0]);
    end
  end

  // Overflow flag: a new overflow wins over a clear and disarms it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tof_reg     <= 1'b0;
      tof_arm_reg <= 1'b0;
    end else if (ovf_evt) begin
      tof_reg     <= 1'b1;
      tof_arm_reg <= 1'b0;
    end else if (rd && sc_hit && tof_reg) begin
      tof_arm_reg <= 1'b1;
    end else if (wr && sc_hit && lo_en) begin
      if (!wb_dat_i[`TPC_FLAG_BIT] && tof_arm_reg) begin
        tof_reg <= 1'b0;
      end
      tof_arm_reg <= 1'b0;
    end
  end

  assign overflow_irq_o = tof_reg & ctl_reg.irq_en;

  // Modulo value, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_reg <= `TPC_CNT_ZERO;
    end else if (wr && mod_hit) begin
      if (lo_en) begin
        mod_reg[7:0] <= wb_dat_i[7:0];
      end
      if (hi_en) begin
        mod_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Pullup enables for pins used as timer inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pue_reg <= '0;
    end else if (wr && pue_hit && lo_en) begin
      pue_reg <= wb_dat_i[`TPC_NUM_CH-1:0];
    end
  end

  tpc_sync u_fix_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (fixed_system_clock_i),
    .level_o (),
    .rise_o  (fix_rise),
    .fall_o  ()
  );

  // sampled at bus rate, so slower sources only
  tpc_sync u_ext_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (external_timer_clock_i),
    .level_o (),
    .rise_o  (ext_rise),
    .fall_o  ()
  );

  always_comb begin
    case (ctl_reg.clks)
      `TPC_CLKS_OFF: src_tick = 1'b0;
      `TPC_CLKS_BUS: src_tick = 1'b1;
      `TPC_CLKS_FIX: src_tick = fix_rise;
      `TPC_CLKS_EXT: src_tick = ext_rise;
      default:       src_tick = 1'b0;
    endcase
  end

  assign pre_hot  = `TPC_HOT_ONE << ctl_reg.ps;
  assign pre_mask = pre_hot[`TPC_PRE_W-1:0] - `TPC_PRE_ONE;
  assign tick     = src_tick && ((pre_reg & pre_mask) == pre_mask);

  // Prescaler counts source edges; cleared while the timer is off
  always_ff @(posedge clk_i) begin
    if (rst_i || ctl_reg.clks == `TPC_CLKS_OFF) begin
      pre_reg <= '0;
    end else if (src_tick) begin
      pre_reg <= pre_reg + `TPC_PRE_ONE;
    end
  end

  assign top = (mod_reg == `TPC_CNT_ZERO) ? `TPC_CNT_FULL : mod_reg;

  // wrap at top in up mode
  // same tick starts the down step
  assign ovf_evt = tick && (dir_reg == TPC_DIR_UP) && (cnt_reg == top);

  // Counter; holds between ticks so a disabled timer freezes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= `TPC_CNT_ZERO;
      dir_reg <= TPC_DIR_UP;
    end else if (cnt_wr) begin
      cnt_reg <= `TPC_CNT_ZERO;
      dir_reg <= TPC_DIR_UP;
    end else if (tick) begin
      case (dir_reg)
        TPC_DIR_UP: begin
          if (cnt_reg != top) begin
            cnt_reg <= cnt_reg + `TPC_CNT_ONE;
          end else if (ctl_reg.centre) begin
            cnt_reg <= cnt_reg - `TPC_CNT_ONE;
            dir_reg <= TPC_DIR_DOWN;
          end else begin
            cnt_reg <= `TPC_CNT_ZERO;
          end
        end
        TPC_DIR_DOWN: begin
          // leaving centre mode resumes up counting
          if (!ctl_reg.centre || cnt_reg == `TPC_CNT_ZERO) begin
            dir_reg <= TPC_DIR_UP;
            cnt_reg <= cnt_reg + `TPC_CNT_ONE;
          end else begin
            cnt_reg <= cnt_reg - `TPC_CNT_ONE;
          end
        end
        default: begin
          dir_reg <= TPC_DIR_UP;
        end
      endcase
    end
  end

  // Channels, each with its own controls
  for (genvar i = 0; i < `TPC_NUM_CH; i++) begin : g_ch
    localparam logic [`TPC_ADR_W-1:0] SC_A =
      `TPC_ADDR_CH_BASE + `TPC_ADR_W'(i) * `TPC_CH_STRIDE;
    localparam logic [`TPC_ADR_W-1:0] VAL_A = SC_A + `TPC_CH_VAL_OFS;

    tpc_chc_t               chc_reg;     // Channel controls
    logic                   flag_reg;    // Channel event flag
    logic                   arm_reg;     // Flag read while set
    logic [`TPC_CNT_W-1:0]  val_reg;     // Channel value
    logic                   pin_reg;     // Output pin level
    logic                   pin_rise;    // Synchronised rising edge
    logic                   pin_fall;    // Synchronised falling edge
    logic                   csc_hit;     // Channel control addressed
    logic                   val_hit;     // Channel value addressed
    logic                   is_cap;      // Input capture selected
    logic                   is_cmp;      // Output compare selected
    logic                   is_pwm;      // Edge-aligned PWM selected
    logic                   match;       // Counter equals value
    logic                   cap_evt;     // Capture edge seen
    logic                   ch_evt;      // Flag-setting event
    logic                   active;      // PWM active level
    logic                   owns;        // Timer drives or samples pin

    assign csc_hit = (wb_adr_i == SC_A);
    assign val_hit = (wb_adr_i == VAL_A);

    // Pin sampled through two flops before any logic sees it
    tpc_sync u_pin_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (channel_pin_i[i]),
      .level_o (),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
    );

    assign is_cap  = !ctl_reg.centre && chc_reg.mode == `TPC_MODE_CAPTURE;
    assign is_cmp  = !ctl_reg.centre && chc_reg.mode == `TPC_MODE_COMPARE;
    assign is_pwm  = !ctl_reg.centre && chc_reg.mode[1];
    assign match   = tick && (cnt_reg == val_reg);
    assign cap_evt = is_cap && ((chc_reg.edge_sel[0] && pin_rise) ||
                                (chc_reg.edge_sel[1] && pin_fall));
    assign ch_evt  = cap_evt || (!is_cap && match);
    assign active  = !chc_reg.edge_sel[0];

    // zero edge select releases the shared pin
    assign owns = (ctl_reg.clks != `TPC_CLKS_OFF) &&
                  (chc_reg.edge_sel != `TPC_EDGE_NONE);

    // Channel controls
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        chc_reg <= tpc_chc_t'(`TPC_CHC_RST);
      end else if (wr && csc_hit && lo_en) begin
        chc_reg <= tpc_chc_t'(wb_dat_i[`TPC_CTL_MSB:`TPC_CHC_LSB]);
      end
    end

    // Channel flag, same clearing handshake as the overflow flag
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flag_reg <= 1'b0;
        arm_reg  <= 1'b0;
      end else if (ch_evt) begin
        flag_reg <= 1'b1;
        arm_reg  <= 1'b0;
      end else if (rd && csc_hit && flag_reg) begin
        arm_reg <= 1'b1;
      end else if (wr && csc_hit && lo_en) begin
        if (!wb_dat_i[`TPC_FLAG_BIT] && arm_reg) begin
          flag_reg <= 1'b0;
        end
        arm_reg <= 1'b0;
      end
    end

    // Channel value; a capture wins over a bus write
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        val_reg <= `TPC_CNT_ZERO;
      end else if (cap_evt) begin
        val_reg <= cnt_reg;
      end else if (wr && val_hit) begin
        if (lo_en) begin
          val_reg[7:0] <= wb_dat_i[7:0];
        end
        if (hi_en) begin
          val_reg[15:8] <= wb_dat_i[15:8];
        end
      end
    end

    // Output level by mode
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_reg <= 1'b0;
      end else if (is_cmp && match) begin
        case (chc_reg.edge_sel)
          `TPC_EDGE_TOGGLE: pin_reg <= ~pin_reg;
          `TPC_EDGE_CLEAR:  pin_reg <= 1'b0;
          `TPC_EDGE_SET:    pin_reg <= 1'b1;
          default:          pin_reg <= pin_reg;
        endcase
      end else if (is_pwm) begin
        // Active from overflow until the match
        if (ovf_evt) begin
          pin_reg <= active;
        end else if (match) begin
          pin_reg <= ~active;
        end
      end else if (ctl_reg.centre) begin
        // Symmetric pulse while the counter is below the value
        pin_reg <= (cnt_reg < val_reg) ? active : ~active;
      end
    end

    assign channel_pin_o[i]       = pin_reg;
    assign channel_pin_oe_o[i]    = owns && !is_cap;
    assign channel_pin_owned_o[i] = owns;
    assign channel_pullup_o[i]    = pue_reg[i] && owns && is_cap;
    assign channel_irq_o[i]       = flag_reg && chc_reg.irq_en;

    always_comb begin
      ch_rd[i] = '0;
      if (csc_hit) begin
        ch_rd[i][`TPC_FLAG_BIT]                  = flag_reg;
        ch_rd[i][`TPC_CTL_MSB:`TPC_CHC_LSB]      = chc_reg;
      end else if (val_hit) begin
        ch_rd[i][`TPC_CNT_W-1:0]                 = val_reg;
      end
    end
  end

endmodule

// ==== logic/tpc_consts.svh ====
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// Register byte addresses on the Wishbone bus
`define TPC_ADDR_SC        8'h00
`define TPC_ADDR_CNT       8'h04
`define TPC_ADDR_MOD       8'h08
`define TPC_ADDR_PUE       8'h0C
`define TPC_ADDR_CH_BASE   8'h10
`define TPC_CH_STRIDE      8'h08
`define TPC_CH_VAL_OFS     8'h04

// Sizes
`define TPC_NUM_CH         2
`define TPC_CNT_W          16
`define TPC_PRE_W          7
`define TPC_ADR_W          8
`define TPC_DAT_W          32

// Counter values
`define TPC_CNT_ZERO       16'h0000
`define TPC_CNT_ONE        16'h0001
`define TPC_CNT_FULL       16'hFFFF

// Clock source select codes
`define TPC_CLKS_OFF       2'h0
`define TPC_CLKS_BUS       2'h1
`define TPC_CLKS_FIX       2'h2
`define TPC_CLKS_EXT       2'h3

// Channel mode and edge/level codes
`define TPC_MODE_CAPTURE   2'h0
`define TPC_MODE_COMPARE   2'h1
`define TPC_EDGE_NONE      2'h0
`define TPC_EDGE_TOGGLE    2'h1
`define TPC_EDGE_CLEAR     2'h2
`define TPC_EDGE_SET       2'h3

// Field positions in the 8-bit status/control words
`define TPC_FLAG_BIT       7
`define TPC_CTL_MSB        6
`define TPC_CHC_LSB        2

// Reset values and prescaler constants
`define TPC_CTL_RST        7'h00
`define TPC_CHC_RST        5'h00
`define TPC_PRE_ONE        7'h01
`define TPC_HOT_ONE        8'h01

`endif

// ==== logic/tpc_pkg.sv ====
package tpc_pkg;

  // Timer control word, low seven bits of the status/control register
  typedef struct packed {
    logic       irq_en;     // Overflow interrupt enable
    logic       centre;     // Centre-aligned select
    logic [1:0] clks;       // Clock source select
    logic [2:0] ps;         // Prescale select
  } tpc_ctl_t;

  // Channel control word, bits 6:2 of a channel status/control register
  typedef struct packed {
    logic       irq_en;     // Channel interrupt enable
    logic [1:0] mode;       // Channel mode select
    logic [1:0] edge_sel;   // Channel edge/level select
  } tpc_chc_t;

  // Counting direction
  typedef enum logic {
    TPC_DIR_UP,
    TPC_DIR_DOWN
  } tpc_dir_t;

endpackage

// ==== logic/tpc_sync.sv ====
`timescale 1ns/10ps

// Two-stage synchroniser with edge detection behind the second stage
module tpc_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic meta_reg;   // First stage, read only by the second
  logic sync_reg;   // Second stage, safe to use
  logic prev_reg;   // Delayed copy for edge detection

  // Shift chain; reset to low so no false edge after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;
  assign fall_o  = ~sync_reg & prev_reg;

endmodule

// ==== sim/tpc_timer_core_monitor.sv ====
`timescale 1ns/10ps
`include "tpc_consts.svh"

// Port-level checks on the timer core
module tpc_timer_core_monitor
  import tpc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  channel_pin_oe_o,
  input wire logic [1:0]  channel_pin_owned_o,
  input wire logic [1:0]  channel_pullup_o,
  input wire logic        overflow_irq_o
);
  logic take;    // Request taken at this edge
  logic ie_reg;  // Shadow of the overflow enable bit

  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Shadow the enable so the request can be judged from ports alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ie_reg <= 1'b0;
    end else if (take && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `TPC_ADDR_SC) begin
      ie_reg <= wb_dat_i[6];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_next: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_hole_zero: assert property (
    take && !wb_we_i && wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_enable: assert property (overflow_irq_o |-> ie_reg)
    else $error("overflow request with enable clear");
  chk_flag_hold: assert property (
    $fell(overflow_irq_o) |->
      $past(take && wb_we_i && wb_adr_i == `TPC_ADDR_SC))
    else $error("overflow request dropped without a write");
  chk_oe_owned: assert property (
    (channel_pin_oe_o & ~channel_pin_owned_o) == 2'h0)
    else $error("pin driven but not owned");
  chk_pull_owned: assert property (
    (channel_pullup_o & ~channel_pin_owned_o) == 2'h0)
    else $error("pullup on a pin not owned");
  chk_reset_quiet: assert property (
    $fell(rst_i) |-> channel_pin_owned_o == 2'h0
      && channel_pullup_o == 2'h0 && !overflow_irq_o)
    else $error("pins or request active after reset");

  cover property ($rose(overflow_irq_o));
  cover property (take && wb_we_i && wb_adr_i == `TPC_ADDR_CNT);
  cover property (channel_pullup_o != 2'h0);
endmodule

bind tpc_timer_core tpc_timer_core_monitor u_mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .channel_pin_oe_o,
  .channel_pin_owned_o, .channel_pullup_o, .overflow_irq_o
);

// ==== sim/tpc_pin_model.sv ====
`timescale 1ns/10ps

// Board side: gated clock sources and channel pin levels
module tpc_pin_model
  import tpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       sel_fix_i,
  input  wire logic [7:0] edges_i,
  output logic            fixed_clk_o,
  output logic            ext_clk_o,
  output logic [1:0]      pin_o
);
  logic [7:0] left_reg;  // Rising edges still to send
  logic [1:0] ph_reg;    // Phase inside one slow period
  logic       tog_reg;   // Idle pin pattern
  logic       burst;     // Clock level during a burst

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_reg <= 8'h00;
      ph_reg   <= 2'h0;
    end else if (go_i) begin
      left_reg <= edges_i;
      ph_reg   <= 2'h0;
    end else if (left_reg != 8'h00) begin
      ph_reg <= ph_reg + 2'h1;
      if (ph_reg == 2'h3) begin
        left_reg <= left_reg - 8'h01;
      end
    end
  end

  // Pattern that changes every cycle, so a stale level never passes
  always_ff @(posedge clk_i) begin
    tog_reg <= rst_i ? 1'b0 : !tog_reg;
  end

  // Clock stands low outside a burst
  assign burst       = (left_reg != 8'h00) && ph_reg[1];
  assign fixed_clk_o = sel_fix_i && burst;
  assign ext_clk_o   = !sel_fix_i && burst;
  assign pin_o       = {tog_reg, ext_clk_o};
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`include "tpc_consts.svh"

// Self-checking bench for the timer core
module tb_top;
  logic        clk_i, rst_i, cyc, stb, we, go, sel_fix;
  logic [7:0]  adr, n_edge;
  logic [31:0] dat, rdat, lo_v, hi_v;
  logic        ack, irq, fclk, fixed_system_clock;
  logic [1:0]  pin_in, pin_out, oe, own, pull, chirq;
  logic [3:0]  sel;
  int          n_fail, cmp_count, cyc_n, t_take, t0, m, n, d;
  logic [31:0] lo_q[$], hi_q[$];  // Expected read ranges

  tpc_timer_core u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .fixed_system_clock_i(fclk),
    .external_timer_clock_i(fixed_system_clock), .channel_pin_i(pin_in),
    .channel_pin_o(pin_out), .channel_pin_oe_o(oe),
    .channel_pin_owned_o(own), .channel_pullup_o(pull),
    .overflow_irq_o(irq), .channel_irq_o(chirq)
  );
  tpc_pin_model u_pins (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .sel_fix_i(sel_fix),
    .edges_i(n_edge), .fixed_clk_o(fclk), .ext_clk_o(fixed_system_clock),
    .pin_o(pin_in)
  );

  // 25 MHz bus clock and a cycle count for timing expectations
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  task automatic fail(input string s);
    n_fail++;
    $display("wrong value at %0t: %s", $time, s);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) fail($sformatf("got %h want %h", got, want));
  endtask

  task end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One classic cycle; a read notes its expected range first
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] dv, lo, hi);
    int k;
    if (!w) begin
      lo_q.push_back(lo);
      hi_q.push_back(hi);
    end
    t_take = cyc_n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= dv;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail("no acknowledge");
      end_of_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // Bounded wait for the overflow request
  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < lim) begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= lim) begin
      fail("no overflow request");
      end_of_test();
    end
  endtask

  // Takes the oldest note whenever read data comes back
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      lo_v = lo_q.pop_front();
      hi_v = hi_q.pop_front();
      cmp_count++;
      if ($isunknown(rdat) || rdat < lo_v || rdat > hi_v)
        fail($sformatf("read %h want %h..%h", rdat, lo_v, hi_v));
    end
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clk_i);
    fail("run too long");
    end_of_test();
  end

  initial begin
    {clk_i, cyc, stb, we, go, sel_fix} = 6'h00;
    rst_i = 1'b1;
    adr = 8'h00;
    sel = 4'h3;
    n_edge = 8'h00;
    dat = 32'h0;
    {n_fail, cmp_count, cyc_n} = '0;
    void'($urandom(91));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Everything clear and every pin left to the port after reset
    chk({oe, own, pull}, 32'h0);
    for (int a = 0; a < 8; a++) acc(0, 8'(a << 2), 0, 0, 0);
    $display("test reset done");
    // Registers keep what was written; a hole reads zero
    d = $urandom & 32'hFFFF;
    acc(1, `TPC_ADDR_MOD, d, 0, 0);
    acc(0, `TPC_ADDR_MOD, 0, d, d);
    d = $urandom & 32'h67;
    acc(1, `TPC_ADDR_SC, d, 0, 0);
    acc(0, `TPC_ADDR_SC, 0, d, d);
    acc(1, 8'h40, 32'hFF, 0, 0);
    acc(0, 8'h40, 0, 0, 0);
    $display("test registers done");
    // Every tap divides the bus clock by its power of two
    for (int k = 0; k < 8; k++) begin
      acc(1, `TPC_ADDR_SC, 0, 0, 0);
      acc(1, `TPC_ADDR_MOD, k[0] ? 32'hFFFF : 32'h0, 0, 0);
      acc(1, `TPC_ADDR_CNT, $urandom, 0, 0);
      acc(1, `TPC_ADDR_SC, 32'h08 | k, 0, 0);
      t0 = t_take;
      repeat (300) @(posedge clk_i);
      d = cyc_n - t0;
      acc(0, `TPC_ADDR_CNT, 0, (d - 3) >> k, d >> k);
    end
    $display("test prescaler done");
    // No source holds the count; any write clears it
    acc(1, `TPC_ADDR_SC, 0, 0, 0);
    acc(1, `TPC_ADDR_CNT, $urandom, 0, 0);
    repeat (40) @(posedge clk_i);
    acc(0, `TPC_ADDR_CNT, 0, 0, 0);
    acc(1, `TPC_ADDR_SC, 32'h08, 0, 0);
    repeat (50) @(posedge clk_i);
    // High byte lane alone still clears the count
    sel <= 4'h2;
    acc(1, `TPC_ADDR_CNT, $urandom, 0, 0);
    sel <= 4'h3;
    acc(0, `TPC_ADDR_CNT, 0, 0, 4);
    $display("test counter clear done");
    // Fixed and pin clocks: one step per synchronised rising edge
    for (int s = 2; s < 4; s++) begin
      n = 5 + $urandom % 40;
      acc(1, `TPC_ADDR_SC, 0, 0, 0);
      acc(1, `TPC_ADDR_CNT, 0, 0, 0);
      acc(1, `TPC_ADDR_SC, s << 3, 0, 0);
      sel_fix <= (s == 2);
      n_edge <= n[7:0];
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (4 * n + 12) @(posedge clk_i);
      acc(0, `TPC_ADDR_CNT, 0, n, n);
    end
    $display("test clock sources done");
    // Overflow timing, its enable and the read-then-write clear
    m = 100 + $urandom % 50;
    acc(1, `TPC_ADDR_SC, 0, 0, 0);
    acc(1, `TPC_ADDR_MOD, m, 0, 0);
    acc(1, `TPC_ADDR_CNT, 0, 0, 0);
    acc(1, `TPC_ADDR_SC, 32'h48, 0, 0);
    wait_irq(m + 20, n);
    chk(n >= m - 2 && n <= m + 4, 1);
    acc(0, `TPC_ADDR_CNT, 0, 0, 4);
    acc(0, `TPC_ADDR_SC, 0, 32'hC8, 32'hC8);
    acc(1, `TPC_ADDR_SC, 32'h88, 0, 0);
    chk(irq, 0);
    acc(1, `TPC_ADDR_SC, 32'h48, 0, 0);
    chk(irq, 1);
    acc(0, `TPC_ADDR_SC, 0, 32'hC8, 32'hC8);
    acc(1, `TPC_ADDR_SC, 32'h08, 0, 0);
    acc(0, `TPC_ADDR_SC, 0, 32'h08, 32'h08);
    $display("test overflow done");
    // Centre mode turns at the modulo and flags at the turn
    m = 20 + $urandom % 20;
    acc(1, `TPC_ADDR_SC, 0, 0, 0);
    acc(1, `TPC_ADDR_MOD, m, 0, 0);
    acc(1, `TPC_ADDR_CNT, 0, 0, 0);
    acc(1, `TPC_ADDR_SC, 32'h68, 0, 0);
    wait_irq(m + 20, n);
    acc(0, `TPC_ADDR_CNT, 0, m - 4, m - 1);
    // Arm, let the next overflow pass, then the zero write must not clear
    acc(0, `TPC_ADDR_SC, 0, 32'hE8, 32'hE8);
    repeat (2 * m) @(posedge clk_i);
    acc(1, `TPC_ADDR_SC, 32'h68, 0, 0);
    acc(0, `TPC_ADDR_SC, 0, 32'hE8, 32'hE8);
    $display("test centre done");
    // Pin ownership follows channel 0's edge field, drive and pullup its mode
    acc(1, `TPC_ADDR_SC, 32'h08, 0, 0);
    acc(1, `TPC_ADDR_PUE, 32'h3, 0, 0);
    acc(1, 8'h18, 32'h04, 0, 0);
    for (int i = 0; i < 16; i++) begin
      acc(1, 8'h10, i << 2, 0, 0);
      chk(own, {1'b1, i[1:0] != 0});
      chk(oe, {1'b0, i[1:0] != 0 && i[3:2] != 0});
      chk(pull, {1'b1, i[1:0] != 0 && i[3:2] == 0});
    end
    acc(1, `TPC_ADDR_SC, 0, 0, 0);
    chk(own, 0);
    $display("test pins done");
    // Mid-run reset, then compare matches with and without a pin
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    acc(0, `TPC_ADDR_MOD, 0, 0, 0);
    acc(0, 8'h10, 0, 0, 0);
    acc(1, 8'h10, 32'h50, 0, 0);
    acc(1, 8'h18, 32'h1C, 0, 0);
    acc(1, 8'h14, 32'h10, 0, 0);
    acc(1, 8'h1C, 32'h10, 0, 0);
    chk({chirq, pin_out[1]}, 0);
    acc(1, `TPC_ADDR_SC, 32'h08, 0, 0);
    repeat (30) @(posedge clk_i);
    chk({chirq, pin_out[1]}, 3);
    acc(0, 8'h10, 0, 32'hD0, 32'hD0);
    $display("test compare done");
    end_of_test();
  end
endmodule
